/* File: logic/eag_base_sel.sv */
`timescale 1ns/100ps
`include "eag_defs.svh"

module eag_base_sel import eag_pkg::*; (
    input wire eag_bases_t bases,
    input wire logic [1:0] sel,
    input wire logic [15:0] disp,
    input wire logic [15:0] idx,
    output eag_addr_t addr
);

    wire eag_addr_t base;

    assign base = (sel == `EAG_BASE_PROC) ? bases.procedure_base :
                  (sel == `EAG_BASE_STACK) ? bases.stack_base :
                  (sel == `EAG_BASE_LINK) ? bases.link_base : bases.auxiliary_base;
    // Offset wraps inside the segment; the segment never carries
    assign addr = {base.seg, base.off + disp + idx};

endmodule : eag_base_sel

/* File: logic/eag_core.sv */
// How it works
// - Stack-relative two-word: address word plus stack pointer, then as long reach.
// - Class 1 gives direct, indexed, indirect, preindexed; class 3 gives postindexed.
// - Base select 00 procedure, 01 stack, 10 link, 11 auxiliary base.
// - Second word of base format is a 16-bit displacement added to base.
// - Indirect, X, Y and base select decode to 32 address forms.
// - Base format pointers are read as 32-bit or 48-bit layout.
// - Base format final address is always memory, never the register file.
// - Load-index and store-index allow only direct and indirect forms.
// - Small sectored mode addresses are 14 bits wide.
// - Small sectored mode: multi-level indexing and indirection, index before pointer.
// - Program counter used points at the instruction itself.
// - Sector bit clear: sector bits of the address are zero.
// - Sector bit set: program counter sector bits joined with displacement.
// - Sector bit clear, direct and unindexed, displacement 0-7 selects a processor register.
// - Mid sectored mode, also relative mid with sector clear, is 15 bits wide.
// - Mid sectored indirect word: 15-bit address, no X flag, chains.
// - Mid sectored indexing once, after all indirection, except low sector-zero case.
// - Sector-zero indirect-indexed: below octal 100 preindex, otherwise postindex.
// - Long reach starts from the word after the instruction, then flags apply.
`timescale 1ns/100ps
`include "eag_defs.svh"

module eag_core import eag_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire eag_req_t req,
    output logic busy,
    output logic mem_rd,
    output eag_addr_t mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_data,
    output logic done,
    output eag_result_t result
);

    function automatic logic [15:0] eag_mask(input eag_mode_t m, input logic [15:0] a);
        case (m)
            MODE_SS: eag_mask = a & `EAG_SS_MASK;
            MODE_SM, MODE_RM: eag_mask = a & `EAG_SM_MASK;
            default: eag_mask = a;
        endcase
    endfunction : eag_mask

    eag_state_t state_ff, nxt_state;
    eag_req_t req_ff, nxt_req;
    logic [15:0] post_ff, nxt_post;
    logic [11:0] seg_ff, nxt_seg;
    logic [15:0] off_ff, nxt_off;
    logic long_ff, nxt_long;
    logic mem_rd_ff, nxt_mem_rd;
    eag_addr_t mem_addr_ff, nxt_mem_addr;
    logic done_ff, nxt_done;
    eag_result_t res_ff, nxt_res;
    logic busy_ff, nxt_busy;

    // Instruction word decode
    wire logic [15:0] ins = req_ff.instr;
    wire logic f_ind = ins[`EAG_I_BIT];
    wire logic f_idx = ins[`EAG_X_BIT];
    wire logic f_sect = ins[`EAG_S_BIT];
    wire logic f_y = ins[`EAG_Y_BIT];
    wire logic [8:0] disp = ins[`EAG_D_MSB:0];
    wire logic [1:0] sel = ins[`EAG_SEL_MSB:0];
    wire eag_mode_t mode = req_ff.mode;
    wire logic is_ss = (mode == MODE_SS);
    wire logic is_sm = (mode == MODE_SM);
    wire logic is_rm = (mode == MODE_RM);
    wire logic is_br = (mode == MODE_BR);

    // Sector-zero and current-sector displacement; pc points at the instruction
    wire logic [15:0] sect_zero = {7'h00, disp};
    wire logic [15:0] sect_cur = {req_ff.pc[15:`EAG_SECT_LSB], disp};
    wire logic [15:0] sect_disp = f_sect ? sect_cur : sect_zero;
    wire logic reg_alias = !f_sect && !f_ind && !f_idx && (disp < `EAG_REG_LIMIT);

    // Small sectored: instruction X always added before any indirection
    wire logic [15:0] ss_start = eag_mask(MODE_SS, sect_disp + (f_idx ? req_ff.x : 16'h0000));

    // Mid sectored: indexed direct forms preindex; indirect forms preindex only in the low sector-zero case
    wire logic sm_pre = f_idx && (!f_ind || (!f_sect && (disp < `EAG_POST_LIMIT)));
    wire logic sm_post = f_idx && f_ind && !sm_pre;
    wire logic [15:0] sm_start = eag_mask(MODE_SM, sect_disp + (sm_pre ? req_ff.x : 16'h0000));

    // Long reach and stack relative two-word
    wire logic rm_stack = sel[0];
    wire logic [15:0] rm_base = req_ff.addr_word + (rm_stack ? req_ff.stack_top_pointer : 16'h0000);
    wire logic rm_pre = f_idx && (!f_ind || !sel[1]);
    wire logic rm_post = f_idx && f_ind && sel[1];
    wire logic [15:0] rm_start = eag_mask(MODE_RM, rm_base + (rm_pre ? req_ff.x : 16'h0000));

    // Base-register two-word: form code is {I, X, Y}
    wire logic [2:0] form = {f_ind, f_idx, f_y};
    wire logic br_ind = f_ind || (f_idx && f_y);
    wire logic br_pre_y = !req_ff.is_index_insn && ((form == 3'h1) || (form == 3'h4));
    wire logic br_pre_x = !req_ff.is_index_insn && ((form == 3'h2) || (form == 3'h6));
    wire logic br_post_y = !req_ff.is_index_insn && (form == 3'h5);
    wire logic br_post_x = !req_ff.is_index_insn && (form == 3'h7);
    wire logic [15:0] br_pre = br_pre_y ? req_ff.y : (br_pre_x ? req_ff.x : 16'h0000);
    wire eag_addr_t br_start;

    eag_base_sel u_base_sel (
        .bases(req_ff.bases),
        .sel(sel),
        .disp(req_ff.addr_word),
        .idx(br_pre),
        .addr(br_start)
    );

    // Selection of the first address for the current mode
    wire logic start_ind = is_br ? br_ind : f_ind;
    wire logic [15:0] start_off = is_ss ? ss_start : (is_sm ? sm_start : (is_rm ? rm_start : br_start.off));
    wire logic [11:0] start_seg = is_br ? br_start.seg : 12'h000;
    wire logic [15:0] start_post = is_sm ? (sm_post ? req_ff.x : 16'h0000) :
                                   is_rm ? (rm_post ? req_ff.x : 16'h0000) :
                                   is_br ? (br_post_y ? req_ff.y : (br_post_x ? req_ff.x : 16'h0000)) :
                                   16'h0000;

    // Pointer chain decode
    wire logic chain_more = mem_data[`EAG_I_BIT];
    wire logic [15:0] ss_ptr = {2'b00, mem_data[13:0]};
    wire logic [15:0] ss_chain = eag_mask(MODE_SS, ss_ptr + (mem_data[`EAG_PTR_IX_BIT] ? req_ff.x : 16'h0000));
    wire logic [15:0] sm_chain = {1'b0, mem_data[14:0]};
    wire logic [15:0] chain_off = is_ss ? ss_chain : sm_chain;
    wire logic [15:0] chain_final = eag_mask(mode, chain_off + post_ff);
    wire logic [15:0] br_final = off_ff + post_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_post = post_ff;
        nxt_seg = seg_ff;
        nxt_off = off_ff;
        nxt_long = long_ff;
        nxt_mem_rd = 1'b0;
        nxt_mem_addr = mem_addr_ff;
        nxt_done = 1'b0;
        nxt_res = res_ff;
        case (state_ff)
            ST_IDLE: begin
                if (req_valid) begin
                    nxt_req = req;
                    nxt_state = ST_CALC;
                end
            end
            ST_CALC: begin
                nxt_post = start_post;
                nxt_long = 1'b0;
                if (start_ind) begin
                    nxt_mem_rd = 1'b1;
                    nxt_mem_addr.seg = start_seg;
                    nxt_mem_addr.off = start_off;
                    nxt_state = ST_PTR;
                end else begin
                    nxt_res.ea.seg = start_seg;
                    nxt_res.ea.off = start_off;
                    nxt_res.is_reg = !is_br && !is_rm && reg_alias;
                    nxt_res.reg_num = disp[2:0];
                    nxt_res.ptr_long = 1'b0;
                    nxt_done = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            ST_PTR: begin
                nxt_mem_rd = 1'b1;
                if (mem_ack) begin
                    if (is_br) begin
                        // First pointer word carries segment and layout
                        nxt_seg = mem_data[`EAG_PTR_SEG_MSB:0];
                        nxt_long = mem_data[`EAG_PTR_LONG_BIT];
                        nxt_mem_addr.off = mem_addr_ff.off + 16'h0001;
                        nxt_state = ST_PTR_LO;
                    end else if (chain_more) begin
                        nxt_mem_addr.seg = 12'h000;
                        nxt_mem_addr.off = chain_off;
                    end else begin
                        nxt_mem_rd = 1'b0;
                        nxt_res.ea.seg = 12'h000;
                        nxt_res.ea.off = chain_final;
                        nxt_res.is_reg = 1'b0;
                        nxt_res.reg_num = 3'h0;
                        nxt_res.ptr_long = 1'b0;
                        nxt_done = 1'b1;
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_PTR_LO: begin
                nxt_mem_rd = 1'b1;
                if (mem_ack) begin
                    nxt_off = mem_data;
                    if (long_ff) begin
                        nxt_mem_addr.off = mem_addr_ff.off + 16'h0001;
                        nxt_state = ST_PTR_EXT;
                    end else begin
                        nxt_mem_rd = 1'b0;
                        nxt_res.ea.seg = seg_ff;
                        nxt_res.ea.off = mem_data + post_ff;
                        nxt_res.is_reg = 1'b0;
                        nxt_res.reg_num = 3'h0;
                        nxt_res.ptr_long = 1'b0;
                        nxt_done = 1'b1;
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_PTR_EXT: begin
                nxt_mem_rd = 1'b1;
                // Third word is the bit offset; it is read to keep the layout but unused here
                if (mem_ack) begin
                    nxt_mem_rd = 1'b0;
                    nxt_res.ea.seg = seg_ff;
                    nxt_res.ea.off = br_final;
                    nxt_res.is_reg = 1'b0;
                    nxt_res.reg_num = 3'h0;
                    nxt_res.ptr_long = 1'b1;
                    nxt_done = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        nxt_busy = (nxt_state != ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            req_ff <= '0;
            post_ff <= 16'h0000;
            seg_ff <= 12'h000;
            off_ff <= 16'h0000;
            long_ff <= 1'b0;
            mem_rd_ff <= 1'b0;
            mem_addr_ff <= '0;
            done_ff <= 1'b0;
            res_ff <= '0;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            post_ff <= nxt_post;
            seg_ff <= nxt_seg;
            off_ff <= nxt_off;
            long_ff <= nxt_long;
            mem_rd_ff <= nxt_mem_rd;
            mem_addr_ff <= nxt_mem_addr;
            done_ff <= nxt_done;
            res_ff <= nxt_res;
            busy_ff <= nxt_busy;
        end
    end

    assign busy = busy_ff;
    assign mem_rd = mem_rd_ff;
    assign mem_addr = mem_addr_ff;
    assign done = done_ff;
    assign result = res_ff;

    // Checks
    default clocking cb_main @(posedge clk); endclocking
    default disable iff (rst);

    wire logic in_calc = (state_ff == ST_CALC);

    chk_read_holds: assert property (
        mem_rd_ff && !mem_ack |=> mem_rd_ff && $stable(mem_addr_ff))
        else $error("memory read dropped before acknowledge");

    chk_chain_follows: assert property (
        (state_ff == ST_PTR) && !is_br && mem_ack && chain_more |=> mem_rd_ff && !done_ff && (state_ff == ST_PTR))
        else $error("indirect chain stopped while indirect flag was set");

    chk_ss_width: assert property (
        done_ff && is_ss |-> (res_ff.ea.off[15:14] == 2'b00))
        else $error("small sectored address wider than 14 bits");

    chk_sm_width: assert property (
        done_ff && (is_sm || is_rm) |-> !res_ff.ea.off[15])
        else $error("mid sectored address wider than 15 bits");

    chk_br_memory: assert property (
        done_ff && is_br |-> !res_ff.is_reg)
        else $error("base format result mapped to a register");

    chk_reg_alias: assert property (
        in_calc && (is_ss || is_sm) && reg_alias |=> done_ff && res_ff.is_reg && (res_ff.reg_num == $past(disp[2:0])))
        else $error("low sector-zero displacement did not select a register");

    chk_sector_zero: assert property (
        in_calc && is_ss && !f_sect && !f_ind && !f_idx |=> done_ff && (res_ff.ea.off[13:9] == 5'h00))
        else $error("sector bits not zero for sector-zero address");

    chk_cur_sector: assert property (
        in_calc && is_sm && f_sect && !f_ind && !f_idx
        |=> done_ff && (res_ff.ea.off == eag_mask(MODE_SM, {$past(req_ff.pc[15:9]), $past(disp)})))
        else $error("current sector address not formed from program counter");

    chk_stack_direct: assert property (
        in_calc && is_rm && rm_stack && !f_ind && !f_idx
        |=> done_ff && (res_ff.ea.off == eag_mask(MODE_RM, $past(req_ff.addr_word) + $past(req_ff.stack_top_pointer))))
        else $error("stack relative direct address wrong");

    chk_index_insn: assert property (
        in_calc && is_br && req_ff.is_index_insn && !br_ind |=> done_ff && (res_ff.ea == $past(br_start))
        && ($past(br_start.off) == $past(req_ff.addr_word) + $past(u_base_sel.base.off)))
        else $error("load or store index used an indexed form");

    chk_ptr_layout: assert property (
        (state_ff == ST_PTR) && is_br && mem_ack
        |=> (state_ff == ST_PTR_LO) && (mem_addr_ff.off == $past(mem_addr_ff.off) + 16'h0001))
        else $error("base pointer second word not read");

    chk_sm_post: assert property (
        in_calc && is_sm && !f_sect && f_ind && f_idx && (disp >= `EAG_POST_LIMIT) |=> (post_ff == $past(req_ff.x)))
        else $error("high sector-zero displacement not postindexed");

    chk_rm_post: assert property (
        in_calc && is_rm && f_ind && f_idx && sel[1] |=> (post_ff == $past(req_ff.x)))
        else $error("class 3 indirect form did not postindex");

    chk_index_no_post: assert property (
        in_calc && is_br && req_ff.is_index_insn |=> (post_ff == 16'h0000))
        else $error("load or store index used a postindexed form");

    chk_mid_chain: assert property (
        (state_ff == ST_PTR) && (is_sm || is_rm) && mem_ack && chain_more
        |=> (mem_addr_ff.off == {1'b0, $past(mem_data[14:0])}))
        else $error("mid sectored pointer not followed as a 15-bit address");

    chk_busy_done: assert property (
        done_ff |-> !busy_ff && !mem_rd_ff)
        else $error("busy or read still raised with done");

    chk_idle_quiet: assert property (
        (state_ff == ST_IDLE) |-> !mem_rd_ff)
        else $error("memory read raised while idle");

    cov_two_levels: cover property ((state_ff == ST_PTR) && mem_ack && chain_more ##[1:20] done_ff);
    cov_long_ptr: cover property (done_ff && res_ff.ptr_long);
    cov_reg_alias: cover property (done_ff && res_ff.is_reg);
    cov_stack_ind: cover property (in_calc && is_rm && rm_stack && f_ind);
    cov_sm_postindex: cover property (in_calc && is_sm && sm_post);

endmodule : eag_core

/* File: logic/eag_defs.svh */
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH

// Instruction word fields (bit 15 is the leftmost bit of the word)
`define EAG_I_BIT 15
`define EAG_X_BIT 14
`define EAG_S_BIT 9
`define EAG_D_MSB 8
`define EAG_Y_BIT 4
`define EAG_SEL_MSB 1
`define EAG_SECT_LSB 9

// Displacement limits
`define EAG_REG_LIMIT 9'h008
`define EAG_POST_LIMIT 9'h040

// Address widths of the sectored modes
`define EAG_SS_MASK 16'h3FFF
`define EAG_SM_MASK 16'h7FFF

// Indirect word fields
`define EAG_PTR_IX_BIT 14
`define EAG_PTR_LONG_BIT 12
`define EAG_PTR_SEG_MSB 11

// Class select values
`define EAG_CLASS_STACK 2'h1
`define EAG_CLASS_STACK_POST 2'h3

// Base select values
`define EAG_BASE_PROC 2'h0
`define EAG_BASE_STACK 2'h1
`define EAG_BASE_LINK 2'h2
`define EAG_BASE_AUX 2'h3

`endif

/* File: logic/eag_pkg.sv */
package eag_pkg;

    typedef enum logic [3:0] {
        MODE_SS = 4'h1,
        MODE_SM = 4'h2,
        MODE_RM = 4'h4,
        MODE_BR = 4'h8
    } eag_mode_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CALC = 5'h02,
        ST_PTR = 5'h04,
        ST_PTR_LO = 5'h08,
        ST_PTR_EXT = 5'h10
    } eag_state_t;

    typedef struct packed {
        logic [11:0] seg;
        logic [15:0] off;
    } eag_addr_t;

    typedef struct packed {
        eag_addr_t procedure_base;
        eag_addr_t stack_base;
        eag_addr_t link_base;
        eag_addr_t auxiliary_base;
    } eag_bases_t;

    typedef struct packed {
        logic [15:0] instr;
        logic [15:0] addr_word;
        logic [15:0] pc;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] stack_top_pointer;
        logic is_index_insn;
        eag_mode_t mode;
        eag_bases_t bases;
    } eag_req_t;

    typedef struct packed {
        eag_addr_t ea;
        logic is_reg;
        logic [2:0] reg_num;
        logic ptr_long;
    } eag_result_t;

endpackage : eag_pkg

/* File: test/eag_mem_model.sv */
`timescale 1ns/100ps

module eag_mem_model import eag_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic mem_rd,
    input wire eag_addr_t mem_addr,
    output logic mem_ack,
    output logic [15:0] mem_data
);
    logic [1:0] wait_ff = 2'h0;
    logic [15:0] junk_ff = 16'h1234;
    integer seed_m = 32'hC5A0;

    // A word that continues a chain points at low three bits that end it, so chains stay short
    function automatic logic [15:0] mem_word(input eag_addr_t a);
        logic [15:0] h;
        logic c;
        h = a.off * 16'h9E37 ^ {4'h0, a.seg};
        c = (a.off[2:0] == 3'h0);
        return {c, h[14] & ~c, 1'b0, h[12:3], a.off[2:0] + 3'h1};
    endfunction : mem_word

    assign mem_ack = mem_rd && (wait_ff == 2'h0);
    // Outside the ack cycle the data keeps moving, so a late sample never matches by luck
    assign mem_data = mem_ack ? mem_word(mem_addr) : junk_ff;

    always @(posedge clk) begin
        junk_ff <= junk_ff + 16'h3B7D;
        if (rst || !mem_rd || mem_ack) begin
            wait_ff <= slow ? 2'($random(seed_m)) : 2'h0;
        end else begin
            wait_ff <= wait_ff - 2'h1;
        end
    end
endmodule : eag_mem_model

/* File: test/effective_address_generator_tb_top.sv */
`timescale 1ns/100ps

module effective_address_generator_tb_top import eag_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic slow = 1'b0;
    eag_req_t req = '0;
    logic busy, mem_rd, mem_ack, done, exp_sect;
    eag_addr_t mem_addr;
    logic [15:0] mem_data;
    eag_result_t result, exp_r;
    eag_addr_t log_q[$], exp_q[$];
    integer err_total = 0, checks = 0, seed = 32'hC5A0, cyc = 0, ack_cyc = 0, k;
    eag_req_t r;

    eag_core u_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .busy(busy), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data), .done(done), .result(result));
    eag_mem_model u_mem (.clk(clk), .rst(rst), .slow(slow), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_data(mem_data));

    always #25 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mem_rd === 1'b1 && mem_ack === 1'b1) begin
            log_q.push_back(mem_addr);
            ack_cyc <= cyc;
        end
    end

    task stop_test;
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task check(input logic ok, input string msg);
        checks = checks + 1;
        if (ok !== 1'b1) begin
            err_total = err_total + 1;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check

    task check_idle;
        check(busy === 1'b0 && mem_rd === 1'b0 && done === 1'b0 && result === '0 && mem_addr === '0, "reset");
    endtask : check_idle

    // Outside base format, sums are kept below the mode width so that wrap handling never decides a result
    function automatic eag_req_t rand_req(input eag_mode_t m);
        eag_req_t q;
        q = '0;
        for (int i = 0; i < 7; i++) q = {q[180:0], 32'($random(seed))};
        q.mode = m;
        q.pc = q.pc & 16'h1FFF;
        q.x = q.x & 16'h1FFF;
        q.stack_top_pointer = q.stack_top_pointer & 16'h1FFF;
        q.is_index_insn = q.is_index_insn && m == MODE_BR;
        if (m == MODE_RM) begin
            q.addr_word = q.addr_word & 16'h1FFF;
            q.instr[9:4] = 6'h30;
            if (q.instr[1]) q.instr[15:14] = 2'b11;
        end
        if (m == MODE_BR) q.instr[9:5] = 5'h18;
        return q;
    endfunction : rand_req

    function automatic logic [15:0] rd(input eag_addr_t a);
        exp_q.push_back(a);
        return u_mem.mem_word(a);
    endfunction : rd

    function automatic void predict(input eag_req_t q);
        logic [2:0] f;
        logic [15:0] a, w, w1, xi, msk;
        logic post, ind, more;
        eag_addr_t b;
        exp_q.delete();
        exp_r = '0;
        exp_sect = (q.mode != MODE_BR);
        msk = (q.mode == MODE_SS) ? 16'h3FFF : 16'h7FFF;
        if (!exp_sect) begin
            f = {q.instr[15:14], q.instr[4]};
            case (q.instr[1:0])
                2'h0: b = q.bases.procedure_base;
                2'h1: b = q.bases.stack_base;
                2'h2: b = q.bases.link_base;
                default: b = q.bases.auxiliary_base;
            endcase
            xi = (q.is_index_insn || f == 3'b000 || f == 3'b011) ? 16'h0 : (f[1] ? q.x : q.y);
            ind = f[2] || f == 3'b011;
            post = f[2] && f[0];
            b.off = b.off + q.addr_word + (post ? 16'h0 : xi);
            if (!ind) begin
                exp_r.ea = b;
            end else begin
                w = rd(b);
                b.off = b.off + 16'h1;
                w1 = rd(b);
                b.off = b.off + 16'h1;
                if (w[12]) void'(rd(b));
                exp_r.ea = {w[11:0], w1 + (post ? xi : 16'h0)};
                exp_r.ptr_long = w[12];
            end
        end else begin
            if (q.mode == MODE_RM) begin
                a = q.addr_word + (q.instr[0] ? q.stack_top_pointer : 16'h0);
                post = q.instr[1];
            end else begin
                a = q.instr[9] ? {q.pc[15:9], q.instr[8:0]} : {7'h0, q.instr[8:0]};
                post = (q.mode == MODE_SM) && (q.instr[9] || q.instr[8:0] >= 9'h040);
            end
            if (q.instr[14] && !post) a = a + q.x;
            more = q.instr[15];
            while (more) begin
                w = rd({12'h0, a & msk});
                more = w[15];
                a = (q.mode == MODE_SS) ? {2'h0, w[13:0]} + (w[14] ? q.x : 16'h0) : {1'b0, w[14:0]};
            end
            if (q.instr[14] && post) a = a + q.x;
            exp_r.ea = {12'h0, a & msk};
            exp_r.is_reg = q.mode != MODE_RM && q.instr[15:14] == 2'b00 && !q.instr[9] && q.instr[8:0] < 9'h008;
            exp_r.reg_num = q.instr[2:0];
        end
    endfunction : predict

    // Entered just after an edge; a refused request is held over the busy span
    task automatic run_one(input eag_req_t q, input logic refuse);
        integer c0, n;
        predict(q);
        log_q.delete();
        req = q;
        req_valid = 1'b1;
        c0 = cyc;
        @(posedge clk);
        #2;
        req_valid = refuse;
        req = ~q;
        check(busy === 1'b1, "busy after take");
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge clk);
            #2;
            n = n + 1;
        end
        check(done === 1'b1 && busy === 1'b0, "done and busy");
        check(cyc === (exp_q.size() > 0 ? ack_cyc + 1 : c0 + 2), "done timing");
        check(log_q.size() === exp_q.size(), "read count");
        foreach (exp_q[i]) if (i < log_q.size())
            check(exp_sect ? (log_q[i].off === exp_q[i].off) : (log_q[i] === exp_q[i]), "read address");
        check(result.is_reg === exp_r.is_reg, "register select");
        if (exp_r.is_reg)
            check(result.reg_num === exp_r.reg_num, "register number");
        else
            check(exp_sect ? (result.ea.off === exp_r.ea.off) : (result.ea === exp_r.ea), "address");
        if (!exp_sect && exp_q.size() > 0)
            check(result.ptr_long === exp_r.ptr_long, "pointer layout");
        if (refuse) begin
            req_valid = 1'b0;
            @(posedge clk);
            #2;
            check(busy === 1'b0, "request taken while busy");
        end
    endtask : run_one

    initial begin
        repeat (15) @(posedge clk);
        #2;
        check_idle();
        @(posedge clk);
        #2 rst = 1'b0;
        @(posedge clk);
        #2;
        for (k = 0; k < 64; k = k + 1) begin
            r = rand_req(MODE_BR);
            {r.is_index_insn, r.instr[15:14], r.instr[4], r.instr[1:0]} = 6'(k);
            run_one(r, k[2]);
        end
        for (k = 0; k < 22; k = k + 1) begin
            r = rand_req(k < 11 ? MODE_SS : MODE_SM);
            r.instr[15:9] = (k % 11 < 9) ? 7'h00 : 7'h60;
            r.instr[8:0] = (k % 11 < 9) ? 9'(k % 11) : (k % 11 == 9 ? 9'h03F : 9'h040);
            run_one(r, 1'b0);
        end
        for (k = 0; k < 400; k = k + 1) begin
            slow = 1'($random(seed));
            r = rand_req(eag_mode_t'(4'h1 << ($unsigned($random(seed)) % 4)));
            run_one(r, k % 5 == 0);
        end
        // Reset lands while an indirect base-format walk is reading
        r = rand_req(MODE_BR);
        r.instr[15] = 1'b1;
        slow = 1'b1;
        req = r;
        req_valid = 1'b1;
        @(posedge clk);
        #2 req_valid = 1'b0;
        @(posedge clk);
        #2 rst = 1'b1;
        @(posedge clk);
        #2;
        check_idle();
        rst = 1'b0;
        @(posedge clk);
        #2;
        run_one(rand_req(MODE_SM), 1'b0);
        stop_test();
    end

    initial begin
        #(20000 * 50);
        err_total = err_total + 1;
        $display("MISMATCH %0t watchdog expired", $time);
        stop_test();
    end
endmodule : effective_address_generator_tb_top
